// *** uart_status_defines.vh ***
`ifndef UART_STATUS_DEFINES_VH
`define UART_STATUS_DEFINES_VH

// register indices; byte address is four times the index
`define IDX_CONTROL 10'h098
`define IDX_BUFFER 10'h099
`define IDX_STATUS 10'h0ba
`define IDX_BAUD 10'h0bb

// serial_port_status fields
`define ST_DBL 7
`define ST_LATE 6
`define ST_SPLIT 5
`define ST_DBL_BUF_IRQ_SELECT 4
`define ST_FE 3
`define ST_BR 2
`define ST_OE 1
`define ST_STATUS_IRQ_ENABLE 0

// serial_port_control fields
`define CT_MHI 7
`define CT_MLO 6
`define CT_MP 5
`define CT_REN 4
`define CT_TB8 3
`define CT_RB8 2
`define CT_TI 1
`define CT_RI 0

// operating modes
`define MODE_SHIFT 2'b00
`define MODE_UART8 2'b01
`define MODE_UART9F 2'b10
`define MODE_UART9V 2'b11

// oversampling and frame positions
`define OVS_RATE 16
`define OVS_LAST 4'hf
`define SMP_A 4'h6
`define SMP_B 4'h7
`define SMP_C 4'h8
`define M0_RISE 4'h8
`define BIT_START 4'h0
`define BIT_EIGHT 4'h9
`define BIT_STOP9 4'ha
`define M0_LAST 3'h7
`define BRK_BITS 11

// reset values
`define RST_STATUS 8'h00
`define RST_CONTROL 8'h00
`define RST_BAUD 16'h0001

`endif

// *** uart_status_rx_ctrl.v ***
// Function
// - status_irq_enable lets frame, break or overrun flags request the serial interrupt.
// - a set rx_done_flag always requests the serial interrupt.
// - overrun_flag sets when bit 8 arrives while rx_done_flag is set.
// - break_flag sets after eleven consecutive low bit times on the line.
// - frame_err_flag sets when the stop bit is not a valid one.
// - with dbl_buf_irq_select, one extra transmit interrupt follows the last character.
// - double buffered write while the transmitter is idle interrupts immediately.
// - split_irq_select separates receive and transmit requests; resets to zero.
// - tx_irq_late moves transmit interrupt from stop start to stop end.
// - dbl_buf_enable selects double-buffer transmit interrupts; buffer writes queue either way; resets to zero.
// - mode 0 buffer write transmits, then sets tx_done_flag until cleared.
// - mode 0 clearing rx_done_flag with the receiver enabled starts reception; completion sets it again.
// - modes 1-3 oversample by sixteen; falling edge restarts the phase counter.
// - each bit is the majority of samples at states seven, eight, nine.
// - a start bit voting high is discarded and the search restarts.
// - mode 1 loads data and stop bit only if flags allow.
// - modes 2 and 3 load only if rx_done_flag clear and address qualifies.
// - modes 2 and 3 put ninth bit in rx_ninth_bit, eight in buffer.
// - mode_select bits pick shift register, 8-bit, 9-bit fixed, 9-bit variable.
// - after a break the receiver idles until high, reporting a framing error.
`timescale 1ns/10ps
`include "uart_status_defines.vh"

module uart_status_rx_ctrl #(
    parameter BAUD_W = 16
) (
    // clock and reset
    input wire clk_i,
    input wire rstn_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    // serial lines
    input wire rxd_i,
    output reg rxd_o,
    output reg rxd_oe_o,
    output reg txd_o,
    // interrupt requests
    output reg irq_rx_o,
    output reg irq_tx_o
);

    localparam RX_IDLE = 2'h0;
    localparam RX_RUN = 2'h1;
    localparam RX_BRK = 2'h2;
    localparam integer BRK_TICKS = `BRK_BITS * `OVS_RATE;
    localparam [7:0] BRK_LAST = BRK_TICKS[7:0] - 8'h01;

    // ****************************************
    // register state
    // ****************************************
    reg [7:0] status_q;
    reg [7:0] control_q;
    reg [BAUD_W-1:0] baud_q;
    reg [7:0] rx_data_q;

    // ****************************************
    // tick, transmitter, receiver state
    // ****************************************
    reg [BAUD_W-1:0] div_q;
    reg tick_q;
    reg tx_busy_q;
    reg [3:0] tx_bit_q;
    reg [3:0] tx_ph_q;
    reg [8:0] tx_sh_q;
    reg buf_full_q;
    reg [8:0] buf_q;
    reg txd_q;
    reg [1:0] rx_st_q;
    reg [3:0] rx_ph_q;
    reg [3:0] rx_bit_q;
    reg [7:0] rx_sh_q;
    reg smp_a_q;
    reg smp_b_q;
    reg rxd_prev_q;
    reg [7:0] brk_cnt_q;
    reg m0_busy_q;
    reg m0_tx_q;
    reg [2:0] m0_bit_q;
    reg [3:0] m0_ph_q;
    reg [7:0] m0_sh_q;

    // ****************************************
    // decode
    // ****************************************
    wire [1:0] mode = {control_q[`CT_MHI], control_q[`CT_MLO]};
    wire mode0 = (mode == `MODE_SHIFT);
    wire nine = (mode == `MODE_UART9F) || (mode == `MODE_UART9V);
    wire dbl = status_q[`ST_DBL];
    wire late = status_q[`ST_LATE];
    wire [9:0] idx = paddr_i[11:2];
    wire hit_ctl = (idx == `IDX_CONTROL);
    wire hit_buf = (idx == `IDX_BUFFER);
    wire hit_st = (idx == `IDX_STATUS);
    wire hit_baud = (idx == `IDX_BAUD);
    wire mapped = hit_ctl | hit_buf | hit_st | hit_baud;
    // write takes effect at the edge where pready is seen high
    wire wr_en = psel_i & penable_i & pready_o & pwrite_i & mapped;
    wire wr_ctl = wr_en & hit_ctl;
    wire wr_buf = wr_en & hit_buf;
    wire wr_st = wr_en & hit_st;

    // ****************************************
    // transmitter events
    // ****************************************
    wire [3:0] tx_stop = nine ? `BIT_STOP9 : `BIT_EIGHT;
    wire tx_adv = tick_q & tx_busy_q & (tx_ph_q == `OVS_LAST);
    wire tx_end = tx_adv & (tx_bit_q == tx_stop);
    wire tx_begin = tx_adv & (tx_bit_q == tx_stop - 4'h1);
    wire tx_pt = late ? tx_end : tx_begin;
    wire tx_load = buf_full_q & (~tx_busy_q | tx_end);
    wire m0_adv = tick_q & m0_busy_q & (m0_ph_q == `OVS_LAST);
    wire m0_done = m0_adv & (m0_bit_q == `M0_LAST);

    // one interrupt per character, plus a final one when the buffer ran dry and dbl_buf_irq_select is set
    wire tx_set = (m0_done & m0_tx_q)
        | (dbl & ~tx_busy_q & buf_full_q)
        | (tx_pt & (~dbl | buf_full_q | status_q[`ST_DBL_BUF_IRQ_SELECT]));

    // ****************************************
    // receiver events
    // ****************************************
    wire rx_act = control_q[`CT_REN] & ~mode0;
    wire fall = tick_q & rxd_prev_q & ~rxd_i;
    wire vote_t = tick_q & (rx_st_q == RX_RUN) & (rx_ph_q == `SMP_C);
    wire voted = (smp_a_q & smp_b_q) | (smp_a_q & rxd_i) | (smp_b_q & rxd_i);
    wire brk_hit = tick_q & rx_act & ~rxd_i & (brk_cnt_q == BRK_LAST);
    wire at_eight = vote_t & (rx_bit_q == `BIT_EIGHT);
    wire at_stop = vote_t & (rx_bit_q == (nine ? `BIT_STOP9 : `BIT_EIGHT));
    // mode 1 stop bit or modes 2/3 ninth bit decides whether the frame is kept
    wire rx_ok = ~control_q[`CT_RI] & (~control_q[`CT_MP] | voted);
    wire rx_load = at_eight & rx_ok & ~brk_hit;
    wire m0_rx_done = m0_done & ~m0_tx_q;
    wire rx_set = rx_load | m0_rx_done;
    wire fe_set = (at_stop & ~voted) | brk_hit;
    wire oe_set = at_eight & control_q[`CT_RI];
    // judged on the mode being written: leaving mode 0 must not start a shift transfer
    wire m0_rx_go = wr_ctl & ({pwdata_i[`CT_MHI], pwdata_i[`CT_MLO]} == `MODE_SHIFT)
        & ~pwdata_i[`CT_RI] & pwdata_i[`CT_REN] & ~m0_busy_q;

    // ****************************************
    // registers
    // ****************************************
    reg [7:0] status_d;
    reg [7:0] control_d;
    always @* begin
        status_d = status_q;
        if (wr_st) begin
            status_d[`ST_DBL] = pwdata_i[`ST_DBL];
            status_d[`ST_LATE] = pwdata_i[`ST_LATE];
            status_d[`ST_SPLIT] = pwdata_i[`ST_SPLIT];
            status_d[`ST_DBL_BUF_IRQ_SELECT] = pwdata_i[`ST_DBL_BUF_IRQ_SELECT];
            status_d[`ST_STATUS_IRQ_ENABLE] = pwdata_i[`ST_STATUS_IRQ_ENABLE];
            // writing one keeps the flag, zero clears it
            status_d[`ST_FE] = status_q[`ST_FE] & pwdata_i[`ST_FE];
            status_d[`ST_BR] = status_q[`ST_BR] & pwdata_i[`ST_BR];
            status_d[`ST_OE] = status_q[`ST_OE] & pwdata_i[`ST_OE];
        end
        // set wins over a clear in the same cycle
        status_d[`ST_FE] = status_d[`ST_FE] | fe_set;
        status_d[`ST_BR] = status_d[`ST_BR] | brk_hit;
        status_d[`ST_OE] = status_d[`ST_OE] | oe_set;
        control_d = control_q;
        if (wr_ctl) begin
            control_d = pwdata_i[7:0];
        end
        if (rx_load) begin
            control_d[`CT_RB8] = voted;
        end
        control_d[`CT_TI] = control_d[`CT_TI] | tx_set;
        control_d[`CT_RI] = control_d[`CT_RI] | rx_set;
    end

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            status_q <= `RST_STATUS;
            control_q <= `RST_CONTROL;
            baud_q <= `RST_BAUD;
            rx_data_q <= 8'h00;
        end else begin
            status_q <= status_d;
            control_q <= control_d;
            if (wr_en & hit_baud) begin
                baud_q <= pwdata_i[BAUD_W-1:0];
            end
            if (rx_load) begin
                rx_data_q <= rx_sh_q;
            end else if (m0_rx_done) begin
                rx_data_q <= m0_sh_q;
            end
        end
    end

    // ****************************************
    // apb response
    // ****************************************
    reg [31:0] rd_d;
    always @* begin
        rd_d = 32'h0000_0000;
        case (1'b1)
            hit_ctl: rd_d[7:0] = control_q;
            hit_buf: rd_d[7:0] = rx_data_q;
            hit_st: rd_d[7:0] = status_q;
            hit_baud: rd_d[BAUD_W-1:0] = baud_q;
            default: rd_d = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            // one wait state: pready rises in the second access cycle
            pready_o <= psel_i & penable_i & ~pready_o;
            pslverr_o <= psel_i & penable_i & ~pready_o & ~mapped;
            if (psel_i & penable_i & ~pready_o) begin
                prdata_o <= rd_d;
            end
        end
    end

    // ****************************************
    // oversampling tick
    // ****************************************
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            div_q <= {BAUD_W{1'b0}};
            tick_q <= 1'b0;
        end else if (div_q == {BAUD_W{1'b0}}) begin
            div_q <= baud_q - {{(BAUD_W-1){1'b0}}, 1'b1};
            tick_q <= 1'b1;
        end else begin
            div_q <= div_q - {{(BAUD_W-1){1'b0}}, 1'b1};
            tick_q <= 1'b0;
        end
    end

    // ****************************************
    // transmitter, modes 1 to 3
    // ****************************************
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            tx_busy_q <= 1'b0;
            tx_bit_q <= `BIT_START;
            tx_ph_q <= 4'h0;
            tx_sh_q <= 9'h000;
            buf_full_q <= 1'b0;
            buf_q <= 9'h000;
            txd_q <= 1'b1;
        end else begin
            if (tx_load) begin
                tx_busy_q <= 1'b1;
                tx_bit_q <= `BIT_START;
                tx_ph_q <= 4'h0;
                tx_sh_q <= buf_q;
            end else if (tx_end) begin
                tx_busy_q <= 1'b0;
            end else if (tx_adv) begin
                tx_bit_q <= tx_bit_q + 4'h1;
                tx_ph_q <= 4'h0;
                if (tx_bit_q != `BIT_START) begin
                    tx_sh_q <= {1'b0, tx_sh_q[8:1]};
                end
            end else if (tick_q & tx_busy_q) begin
                tx_ph_q <= tx_ph_q + 4'h1;
            end
            // buffer write outside mode 0 queues; the ninth bit travels with it
            if (wr_buf & ~mode0) begin
                buf_full_q <= 1'b1;
                buf_q <= {control_q[`CT_TB8], pwdata_i[7:0]};
            end else if (tx_load) begin
                buf_full_q <= 1'b0;
            end
            if (~tx_busy_q) begin
                txd_q <= 1'b1;
            end else if (tx_bit_q == `BIT_START) begin
                txd_q <= 1'b0;
            end else if (tx_bit_q == tx_stop) begin
                txd_q <= 1'b1;
            end else begin
                txd_q <= tx_sh_q[0];
            end
        end
    end

    // ****************************************
    // receiver, modes 1 to 3
    // ****************************************
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            rx_st_q <= RX_IDLE;
            rx_ph_q <= 4'h0;
            rx_bit_q <= `BIT_START;
            rx_sh_q <= 8'h00;
            smp_a_q <= 1'b1;
            smp_b_q <= 1'b1;
            rxd_prev_q <= 1'b1;
            brk_cnt_q <= 8'h00;
        end else begin
            if (tick_q) begin
                rxd_prev_q <= rxd_i;
                if (rx_act & ~rxd_i & (brk_cnt_q != BRK_LAST)) begin
                    brk_cnt_q <= brk_cnt_q + 8'h01;
                end else if (rxd_i | ~rx_act) begin
                    brk_cnt_q <= 8'h00;
                end
            end
            if (brk_hit) begin
                rx_st_q <= RX_BRK;
            end else begin
                case (rx_st_q)
                    RX_IDLE: begin
                        if (rx_act & fall) begin
                            rx_st_q <= RX_RUN;
                            rx_ph_q <= 4'h0;
                            rx_bit_q <= `BIT_START;
                        end
                    end
                    RX_RUN: begin
                        if (~rx_act) begin
                            rx_st_q <= RX_IDLE;
                        end else if (tick_q) begin
                            rx_ph_q <= rx_ph_q + 4'h1;
                            if (rx_ph_q == `OVS_LAST) begin
                                rx_bit_q <= rx_bit_q + 4'h1;
                            end
                            if (rx_ph_q == `SMP_A) begin
                                smp_a_q <= rxd_i;
                            end
                            if (rx_ph_q == `SMP_B) begin
                                smp_b_q <= rxd_i;
                            end
                        end
                        if (vote_t) begin
                            if ((rx_bit_q == `BIT_START) & voted) begin
                                rx_st_q <= RX_IDLE;
                            end else if (at_stop) begin
                                rx_st_q <= RX_IDLE;
                            end else if (rx_bit_q != `BIT_START && rx_bit_q != `BIT_EIGHT) begin
                                rx_sh_q <= {voted, rx_sh_q[7:1]};
                            end
                        end
                    end
                    RX_BRK: begin
                        if (tick_q & rxd_i) begin
                            rx_st_q <= RX_IDLE;
                        end
                    end
                    default: rx_st_q <= RX_IDLE;
                endcase
            end
        end
    end

    // ****************************************
    // shift-register mode 0
    // ****************************************
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            m0_busy_q <= 1'b0;
            m0_tx_q <= 1'b0;
            m0_bit_q <= 3'h0;
            m0_ph_q <= 4'h0;
            m0_sh_q <= 8'h00;
        end else if (~m0_busy_q) begin
            m0_bit_q <= 3'h0;
            m0_ph_q <= 4'h0;
            if (wr_buf & mode0) begin
                m0_busy_q <= 1'b1;
                m0_tx_q <= 1'b1;
                m0_sh_q <= pwdata_i[7:0];
            end else if (m0_rx_go) begin
                m0_busy_q <= 1'b1;
                m0_tx_q <= 1'b0;
            end
        end else if (tick_q) begin
            m0_ph_q <= m0_ph_q + 4'h1;
            if (~m0_tx_q && m0_ph_q == `M0_RISE) begin
                m0_sh_q <= {rxd_i, m0_sh_q[7:1]};
            end
            if (m0_ph_q == `OVS_LAST) begin
                m0_bit_q <= m0_bit_q + 3'h1;
                if (m0_tx_q) begin
                    m0_sh_q <= {1'b0, m0_sh_q[7:1]};
                end
                if (m0_bit_q == `M0_LAST) begin
                    m0_busy_q <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // pins and interrupt requests
    // ****************************************
    wire stat_req = status_q[`ST_STATUS_IRQ_ENABLE]
        & (status_q[`ST_FE] | status_q[`ST_BR] | status_q[`ST_OE]);
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            txd_o <= 1'b1;
            rxd_o <= 1'b1;
            rxd_oe_o <= 1'b0;
            irq_rx_o <= 1'b0;
            irq_tx_o <= 1'b0;
        end else begin
            // mode 0 drives the shift clock low in the first half of each bit
            txd_o <= mode0 ? (~m0_busy_q | m0_ph_q[3]) : txd_q;
            rxd_o <= m0_sh_q[0];
            rxd_oe_o <= mode0 & m0_busy_q & m0_tx_q;
            if (status_q[`ST_SPLIT]) begin
                irq_rx_o <= control_q[`CT_RI] | stat_req;
                irq_tx_o <= control_q[`CT_TI];
            end else begin
                irq_rx_o <= control_q[`CT_RI] | control_q[`CT_TI] | stat_req;
                irq_tx_o <= 1'b0;
            end
        end
    end

endmodule // uart_status_rx_ctrl

// *** uart_status_rx_ctrl_monitor.sv ***
`timescale 1ns/10ps
`include "uart_status_defines.vh"
module uart_status_rx_ctrl_monitor (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // serial and requests
    input wire logic rxd_oe_o,
    input wire logic irq_rx_o,
    input wire logic irq_tx_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // ****************************************
    // shadow of software settings
    // ****************************************
    logic [1:0] mode_q;
    logic split_q;
    wire wr_done = psel_i && penable_i && pready_o && pwrite_i;
    wire mapped = paddr_i[11:2] == `IDX_CONTROL || paddr_i[11:2] == `IDX_BUFFER
        || paddr_i[11:2] == `IDX_STATUS || paddr_i[11:2] == `IDX_BAUD;
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            mode_q <= `MODE_SHIFT;
            split_q <= 1'b0;
        end else if (wr_done) begin
            if (paddr_i[11:2] == `IDX_CONTROL) mode_q <= pwdata_i[7:6];
            if (paddr_i[11:2] == `IDX_STATUS) split_q <= pwdata_i[`ST_SPLIT];
        end
    end
    // ****************************************
    // properties
    // ****************************************
    sequence s_access;
        psel_i && penable_i && !pready_o ##1 pready_o;
    endsequence
    property p_answer;
        psel_i && !penable_i |=> s_access;
    endproperty
    property p_pulse;
        pready_o |=> !pready_o;
    endproperty
    property p_err_unmapped;
        pready_o && !mapped |-> pslverr_o && (pwrite_i || prdata_o == 32'h0);
    endproperty
    property p_err_mapped;
        pready_o && mapped |-> !pslverr_o;
    endproperty
    property p_rd_upper;
        pready_o && !pwrite_i |-> prdata_o[31:16] == 16'h0;
    endproperty
    property p_rd_hold;
        !(psel_i && penable_i) |=> $stable(prdata_o);
    endproperty
    property p_combined;
        (!split_q) [*3] |-> !irq_tx_o;
    endproperty
    property p_oe_mode;
        (mode_q != `MODE_SHIFT) [*3] |-> !rxd_oe_o;
    endproperty
    property p_reset_quiet;
        $rose(rstn_i) |-> !irq_rx_o && !irq_tx_o && !rxd_oe_o;
    endproperty
    a_answer: assert property (p_answer) else $error("ready not one cycle into access");
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
    a_err_mapped: assert property (p_err_mapped) else $error("mapped access refused");
    a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved outside access");
    a_combined: assert property (p_combined) else $error("tx request while combined");
    a_oe_mode: assert property (p_oe_mode) else $error("data pin driven outside mode 0");
    a_reset_quiet: assert property (p_reset_quiet) else $error("output active at reset");
endmodule // uart_status_rx_ctrl_monitor

bind uart_status_rx_ctrl uart_status_rx_ctrl_monitor mon (.clk_i(clk_i), .rstn_i(rstn_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .rxd_oe_o(rxd_oe_o), .irq_rx_o(irq_rx_o), .irq_tx_o(irq_tx_o));

// *** serial_peer.sv ***
`timescale 1ns/10ps
module serial_peer (
    // clock
    input wire logic clk_i,
    // line toward the receiver
    output logic line_o
);
    // ****************************************
    // remote sender, one tick per clock
    // ****************************************
    initial line_o = 1'b1;
    // start bit then n bits lsb first; g flips one of the three vote samples
    task automatic frame(input logic [9:0] bits, input int n, input bit g);
        int i;
        int k;
        logic b;
        for (i = 0; i <= n; i++) begin
            b = (i == 0) ? 1'b0 : bits[i-1];
            for (k = 0; k < 16; k++) begin
                line_o <= (g && k == 7) ? ~b : b;
                @(posedge clk_i);
            end
        end
        line_o <= 1'b1;
        repeat (16) @(posedge clk_i);
    endtask
    task automatic hold_low(input int n);
        line_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        line_o <= 1'b1;
        repeat (32) @(posedge clk_i);
    endtask
endmodule // serial_peer

// *** uart_status_rx_ctrl_tb_top.sv ***
`timescale 1ns/10ps
`include "uart_status_defines.vh"
module uart_status_rx_ctrl_tb_top;
    logic clk_i, rstn_i, psel_i, penable_i, pwrite_i, tx_prev, nine;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, rxd_o, rxd_oe_o, txd_o, irq_rx_o, irq_tx_o, line;
    // two-way data pin: design drives only in mode 0 transmit
    wire rxd_w = rxd_oe_o ? rxd_o : line;
    int err_count, check_count, i;
    logic [63:0] exp_q[$];
    logic [63:0] note;
    logic [7:0] d, sh, ctl;
    localparam logic [11:0] A_CTL = {`IDX_CONTROL, 2'b00};
    localparam logic [11:0] A_BUF = {`IDX_BUFFER, 2'b00};
    localparam logic [11:0] A_ST = {`IDX_STATUS, 2'b00};
    localparam logic [11:0] A_BAUD = {`IDX_BAUD, 2'b00};

    uart_status_rx_ctrl #(.BAUD_W(16)) dut (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .rxd_i(rxd_w),
        .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o), .irq_rx_o(irq_rx_o),
        .irq_tx_o(irq_tx_o));
    serial_peer peer (.clk_i(clk_i), .line_o(line));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // ****************************************
    // bus master and result checking
    // ****************************************
    task test_done;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        int n;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= v;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (pready_o !== 1'b1) begin
            err_count++;
            test_done;
        end
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] v);
        apb(1'b1, a, v);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back({m, e & m});
        apb(1'b0, a, 32'h0);
    endtask
    always @(posedge clk_i) begin
        if (psel_i && penable_i && pready_o && !pwrite_i) begin
            note = exp_q.pop_front();
            chk(prdata_o & note[63:32], note[31:0]);
        end
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        {rstn_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        err_count = 0;
        check_count = 0;
        d = $urandom(68);
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd(A_ST, 32'h0, 32'hff);
        rd(A_CTL, 32'h0, 32'hff);
        rd(A_BAUD, 32'h1, 32'hffff);
        rd(12'h000, 32'h0, 32'hffffffff);
        $display("test reset done");
        wr(A_CTL, 32'h50);
        d = $urandom;
        peer.frame({2'b01, d}, 9, 1'b1);
        rd(A_CTL, 32'h55, 32'hff);
        rd(A_BUF, d, 32'hff);
        chk(irq_rx_o, 32'h1);
        peer.frame({2'b01, ~d}, 9, 1'b0);
        rd(A_ST, 32'h02, 32'hff);
        rd(A_BUF, d, 32'hff);
        wr(A_CTL, 32'h50);
        repeat (2) @(posedge clk_i);
        chk(irq_rx_o, 32'h0);
        wr(A_ST, 32'h03);
        repeat (2) @(posedge clk_i);
        chk(irq_rx_o, 32'h1);
        rd(A_ST, 32'h03, 32'hff);
        wr(A_ST, 32'h01);
        rd(A_ST, 32'h01, 32'hff);
        $display("test overrun done");
        peer.frame({2'b00, d}, 9, 1'b0);
        rd(A_ST, 32'h09, 32'hff);
        rd(A_CTL, 32'h51, 32'hff);
        wr(A_CTL, 32'h50);
        wr(A_ST, 32'h00);
        peer.hold_low(5);
        d = $urandom;
        peer.frame({2'b01, d}, 9, 1'b0);
        rd(A_CTL, 32'h55, 32'hff);
        rd(A_BUF, d, 32'hff);
        peer.hold_low(16 * 12);
        rd(A_ST, 32'h0c, 32'h0c);
        wr(A_ST, 32'h00);
        $display("test errors done");
        for (i = 0; i < 3; i++) begin
            ctl = (i == 0) ? 8'h90 : 8'hf0;
            nine = (i != 1);
            wr(A_CTL, ctl);
            d = $urandom;
            peer.frame({1'b1, nine, d}, 10, 1'b0);
            rd(A_CTL, nine ? ctl | 8'h05 : ctl, 32'hff);
            if (nine) rd(A_BUF, d, 32'hff);
        end
        $display("test nine bit done");
        wr(A_ST, 32'h00);
        wr(A_CTL, 32'h00);
        d = $urandom;
        sh = 8'h00;
        tx_prev = 1'b1;
        wr(A_BUF, d);
        repeat (400) begin
            @(posedge clk_i);
            if (rxd_oe_o && txd_o && !tx_prev) sh = {rxd_o, sh[7:1]};
            tx_prev = txd_o;
        end
        chk(sh, d);
        rd(A_CTL, 32'h02, 32'hff);
        chk(irq_rx_o, 32'h1);
        wr(A_ST, 32'h20);
        repeat (2) @(posedge clk_i);
        chk({irq_tx_o, irq_rx_o}, 32'h2);
        wr(A_ST, 32'h00);
        wr(A_CTL, 32'h10);
        repeat (400) @(posedge clk_i);
        rd(A_CTL, 32'h11, 32'hfb);
        rd(A_BUF, 32'hff, 32'hff);
        $display("test mode 0 done");
        wr(A_CTL, 32'h40);
        wr(A_ST, 32'ha0);
        wr(A_BUF, d);
        repeat (3) @(posedge clk_i);
        chk(irq_tx_o, 32'h1);
        wr(A_CTL, 32'h40);
        repeat (200) @(posedge clk_i);
        rd(A_CTL, 32'h40, 32'hff);
        wr(A_ST, 32'hf0);
        wr(A_BUF, d);
        wr(A_CTL, 32'h40);
        repeat (146) @(posedge clk_i);
        rd(A_CTL, 32'h00, 32'h02);
        repeat (20) @(posedge clk_i);
        rd(A_CTL, 32'h02, 32'h02);
        $display("test double buffer done");
        test_done;
    end
endmodule // uart_status_rx_ctrl_tb_top
